// [rtl/lrb_ram_block.sv]
`timescale 1ns/1ps
// Overview of operation
// [R1] Storage is 589,824 bits including parity
// [R2] Modes: true dual, simple dual, single, FIFO
// [R3] No preload; contents undefined until written
// [R4] Synchronous only; all inputs registered first
// [R5] Read output register is optional, bypassable
// [R6] Widths 9 to 144, depth scales inversely
// [R7] 144-bit width refused in true dual port
// [R8] Simple dual: 144 pairs only with 144
// [R9] True dual: any 9..72 width pairing
// [R10] One write enable selects read or write
// [R11] Byte written when write and enable high
// [R12] Byte masking in 18, 36, 72 widths
// [R13] 144-bit mode joins both enable groups
// [R14] Enable bit i covers bits 9i+8..9i
// [R15] Combined bit i covers 9i+8..9i, i<16
// [R16] Any enable pattern, bytes written independently
// [R17] Without parity, 8-bit bytes masked likewise
// [R18] All input registers share one clock
// [R19] Masked bytes keep their previous contents
module lrb_ram_block (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          pclken,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [lrb_pkg::PADDR_W-1:0]   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic                               pready,
    output logic [31:0]                        prdata,
    output logic                               pslverr
);
    import lrb_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic                         rdy;
        logic                         slverr;
        logic [31:0]                  rdata;
        logic [CFG_W-1:0]             cfg;
        logic [1:0][ADDR_W-1:0]       addr;
        logic [1:0][BE_W-1:0]         be;
        logic [1:0][DATA_W-1:0]       wd;
        logic [1:0]                   go;
        logic [1:0]                   we;
        logic [1:0]                   rv;
        logic [1:0][DATA_W-1:0]       q;
        logic [ADDR_W-1:0]            wptr;
        logic [ADDR_W-1:0]            rptr;
        logic [ADDR_W:0]              cnt;
    } lrb_state_t;

    localparam lrb_state_t ST_RST = '{cfg: CFG_RST, be: {2{BYTEEN_RST}}, default: '0};

    lrb_state_t                  s_reg;
    lrb_state_t                  s_next;
    lrb_mode_t                   mode;
    logic [1:0][2:0]             wcode;
    logic                        nopar;
    logic                        cfg_err;
    logic                        fifo_empty;
    logic                        fifo_full;
    logic [ADDR_W:0]             depth;
    logic [ADDR_W-1:0]           ptr_mask;
    logic [1:0][LANES-1:0]       be16;
    logic [1:0][LANES-1:0]       lane_en;
    logic [1:0][ADDR_W-1:0]      core_base;
    logic [1:0][DATA_W-1:0]      core_wd;
    logic [1:0][DATA_W-1:0]      raw;
    logic [1:0][DATA_W-1:0]      dout;
    logic [1:0][DATA_W-1:0]      rd_out;
    logic                        pi;
    logic                        in_port;
    logic [6:0]                  off;
    logic [2:0]                  k;
    logic                        hit;
    logic [31:0]                 rd_val;
    logic [159:0]                wd_w;
    logic [159:0]                rd_w;
    logic [159:0]                wd_mod;
    logic                        wr_acc;
    logic                        cmd_wr;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [LANES-1:0] lane_mask(input logic [2:0] w);
        case (w)
            W9:      lane_mask = 16'h0001;
            W18:     lane_mask = 16'h0003;
            W36:     lane_mask = 16'h000f;
            W72:     lane_mask = 16'h00ff;
            default: lane_mask = 16'hffff;
        endcase
    endfunction

    // Parity-less widths carry 8-bit bytes; the ninth lane bit is zero
    function automatic logic [DATA_W-1:0] pack(input logic [DATA_W-1:0] d, input logic np);
        pack = d;
        if (np) begin
            for (int i = 0; i < LANES; i++) begin
                pack[i*LANE_W +: LANE_W] = {1'b0, d[i*8 +: 8]}; // [R17]
            end
        end
    endfunction

    function automatic logic [DATA_W-1:0] unpack(input logic [DATA_W-1:0] r, input logic np);
        unpack = r;
        if (np) begin
            unpack = '0;
            for (int i = 0; i < LANES; i++) begin
                unpack[i*8 +: 8] = r[i*LANE_W +: 8];
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // Configuration decode
    // ---------------------------------------------------------------
    assign mode       = lrb_mode_t'(s_reg.cfg[CFG_MODE +: 2]);
    assign wcode[0]   = s_reg.cfg[CFG_WA +: 3];
    assign wcode[1]   = s_reg.cfg[CFG_WB +: 3];
    assign nopar      = s_reg.cfg[CFG_NOPAR];
    assign depth      = 17'h1_0000 >> wcode[0]; // [R6]
    assign ptr_mask   = 16'hffff >> wcode[0];
    assign fifo_empty = s_reg.cnt == '0;
    assign fifo_full  = s_reg.cnt == depth;

    always_comb begin
        cfg_err = (wcode[0] > W144) || (wcode[1] > W144);
        case (mode)
            MODE_TDP:  cfg_err = cfg_err || wcode[0] == W144 || wcode[1] == W144; // [R7] [R9]
            MODE_SDP:  cfg_err = cfg_err || ((wcode[0] == W144) != (wcode[1] == W144)); // [R8]
            MODE_FIFO: cfg_err = cfg_err || wcode[0] != wcode[1];
            default:   cfg_err = cfg_err;
        endcase
    end

    // ---------------------------------------------------------------
    // Datapath to the array
    // ---------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            if (wcode[p] == W144) begin
                be16[p] = {s_reg.be[1], s_reg.be[0]}; // [R13] [R15]
            end else if (wcode[p] == W9) begin
                be16[p] = '1;
            end else begin
                be16[p] = {8'h00, s_reg.be[p]}; // [R12] [R14]
            end
            lane_en[p]   = s_reg.we[p] ? (lane_mask(wcode[p]) & be16[p]) : lane_mask(wcode[p]); // [R11]
            core_base[p] = ADDR_W'(s_reg.addr[p] << wcode[p]);
            core_wd[p]   = pack(s_reg.wd[p], nopar);
            dout[p]      = unpack(raw[p], nopar);
            rd_out[p]    = s_reg.cfg[CFG_OREG_A + p] ? s_reg.q[p] : dout[p]; // [R5]
        end
    end

    lrb_ram_core u_core (
        .clk     (pclk),
        .ce      (pclken),
        .en      (s_reg.go),
        .we      (s_reg.we),
        .base    (core_base),
        .lane_en (lane_en),
        .wdata   (core_wd),
        .rdata   (raw)
    );

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    always_comb begin
        pi      = paddr[8];
        in_port = (paddr[11:9] == 3'h0) && (paddr[8] != paddr[7]);
        off     = paddr[6:0];
        k       = paddr[4:2];
        wd_w    = {16'h0000, s_reg.wd[pi]};
        rd_w    = {16'h0000, rd_out[pi]};
        wd_mod  = wd_w;
        wd_mod[k*32 +: 32] = pwdata;
        hit     = 1'b1;
        rd_val  = '0;
        if (!in_port) begin
            case (paddr)
                OFS_CFG:      rd_val = 32'(s_reg.cfg);
                OFS_STATUS:   rd_val = {27'h000_0000, s_reg.go | s_reg.rv, fifo_full,
                                        fifo_empty, cfg_err};
                OFS_FIFO_CNT: rd_val = 32'(s_reg.cnt);
                default:      hit = 1'b0;
            endcase
        end else if (off == REG_ADDR) begin
            rd_val = 32'(s_reg.addr[pi]);
        end else if (off == REG_BYTEEN) begin
            rd_val = 32'(s_reg.be[pi]);
        end else if (off == REG_CMD) begin
            rd_val = '0;
        end else if (off[6:5] == REG_WDATA[6:5] && k < DATA_WORDS) begin
            rd_val = wd_w[k*32 +: 32];
        end else if (off[6:5] == REG_RDATA[6:5] && k < DATA_WORDS) begin
            rd_val = rd_w[k*32 +: 32];
        end else begin
            hit = 1'b0;
        end
    end

    assign wr_acc = psel && penable && s_reg.rdy && pwrite && hit;
    assign cmd_wr = wr_acc && in_port && off == REG_CMD;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_next        = s_reg;
        s_next.go     = 2'b00;
        s_next.rv     = s_reg.go & ~s_reg.we;
        s_next.rdy    = psel && !penable;
        s_next.slverr = psel && !penable && !hit;
        if (psel && !penable) begin
            s_next.rdata = rd_val;
        end
        for (int p = 0; p < 2; p++) begin
            if (s_reg.rv[p] && s_reg.cfg[CFG_OREG_A + p]) begin
                s_next.q[p] = dout[p];
            end
        end
        if (wr_acc && !in_port && paddr == OFS_CFG) begin
            s_next.cfg  = pwdata[CFG_W-1:0];
            s_next.wptr = '0;
            s_next.rptr = '0;
            s_next.cnt  = '0;
        end
        if (wr_acc && in_port) begin
            if (off == REG_ADDR) begin
                s_next.addr[pi] = pwdata[ADDR_W-1:0];
            end else if (off == REG_BYTEEN) begin
                s_next.be[pi] = pwdata[BE_W-1:0];
            end else if (off[6:5] == REG_WDATA[6:5] && k < DATA_WORDS) begin
                s_next.wd[pi] = wd_mod[DATA_W-1:0];
            end
        end
        // Bit 0 of the command selects read or write; simple dual and FIFO fix the direction per port
        if (cmd_wr && !cfg_err) begin // [R10]
            case (mode)
                MODE_TDP: begin
                    s_next.go[pi] = 1'b1;
                    s_next.we[pi] = pwdata[0];
                end
                MODE_SDP: begin // [R2]
                    s_next.go[pi] = pwdata[0] == !pi;
                    s_next.we[pi] = !pi;
                end
                MODE_SP: begin
                    s_next.go[0] = !pi;
                    s_next.we[0] = pwdata[0];
                end
                MODE_FIFO: begin
                    if (!pi && pwdata[0] && !fifo_full) begin
                        s_next.go[0]   = 1'b1;
                        s_next.we[0]   = 1'b1;
                        s_next.addr[0] = s_reg.wptr;
                        s_next.wptr    = (s_reg.wptr + 1'b1) & ptr_mask;
                        s_next.cnt     = s_reg.cnt + 1'b1;
                    end else if (pi && !pwdata[0] && !fifo_empty) begin
                        s_next.go[1]   = 1'b1;
                        s_next.we[1]   = 1'b0;
                        s_next.addr[1] = s_reg.rptr;
                        s_next.rptr    = (s_reg.rptr + 1'b1) & ptr_mask;
                        s_next.cnt     = s_reg.cnt - 1'b1;
                    end
                end
                default: s_next.go = 2'b00;
            endcase
        end
    end

    // Single clock for every captured input keeps both ports coherent
    always_ff @(posedge pclk or negedge presetn) begin // [R4] [R18]
        if (!presetn) begin
            s_reg <= ST_RST;
        end else if (pclken) begin
            s_reg <= s_next;
        end
    end

    assign pready  = s_reg.rdy;
    assign prdata  = s_reg.rdata;
    assign pslverr = s_reg.slverr;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !pclken);
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_CMD_TO_GO: assert property (cmd_wr && mode == MODE_TDP && !cfg_err // [R4]
        |=> s_reg.go[$past(pi)] && s_reg.we[$past(pi)] == $past(pwdata[0]))
        else $error("command did not start the port");
    AST_TDP144_ERR: assert property (cmd_wr && mode == MODE_TDP // [R7]
        && (wcode[0] == W144 || wcode[1] == W144) |=> s_reg.go == 2'b00)
        else $error("144-bit true dual port accepted a command");
    AST_SDP144_ERR: assert property (cmd_wr && mode == MODE_SDP // [R8]
        && ((wcode[0] == W144) != (wcode[1] == W144)) |=> s_reg.go == 2'b00)
        else $error("mismatched 144-bit pairing accepted a command");
    AST_ERR_BLOCKS: assert property (cmd_wr && cfg_err |=> s_reg.go == 2'b00) // [R9]
        else $error("operation started on illegal configuration");
    AST_SDP_B_READ: assert property (mode == MODE_SDP && s_reg.go[1] |-> !s_reg.we[1]) // [R2]
        else $error("simple dual port B wrote");
    AST_OREG_LAG: assert property (s_reg.rv[0] && s_reg.cfg[CFG_OREG_A] // [R5]
        |=> s_reg.q[0] == $past(dout[0]))
        else $error("output register missed read data");
    AST_BUSY_CLEARS: assert property (s_reg.go[0] |=> !s_reg.go[0] ##1 !s_reg.rv[0]) // [R4]
        else $error("port A busy beyond two cycles");
    AST_FIFO_REFUSES: assert property (cmd_wr && mode == MODE_FIFO // [R2]
        && (pi ? fifo_empty : fifo_full) |=> s_reg.go == 2'b00 && $stable(s_reg.cnt))
        else $error("FIFO operation accepted past its limit");

    COV_TDP_WRITE: cover property (cmd_wr && mode == MODE_TDP && pwdata[0]);
    COV_SDP_144:   cover property (s_reg.go[0] && s_reg.we[0] && wcode[0] == W144);
    COV_FIFO_POP:  cover property (s_reg.go[1] && mode == MODE_FIFO);
    COV_OREG_READ: cover property (s_reg.rv[1] && s_reg.cfg[CFG_OREG_A + 1]);

endmodule

// [inc/lrb_pkg.sv]
package lrb_pkg;

    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int CAPACITY_BITS = 589824;
    localparam int LANE_W        = 9;
    localparam int MEM_BYTES     = CAPACITY_BITS / LANE_W;
    localparam int ADDR_W        = 16;
    localparam int LANES         = 16;
    localparam int DATA_W        = 144;
    localparam int BE_W          = 8;
    localparam int PADDR_W       = 12;
    localparam int CFG_W         = 11;

    localparam logic [2:0] W9    = 3'h0;
    localparam logic [2:0] W18   = 3'h1;
    localparam logic [2:0] W36   = 3'h2;
    localparam logic [2:0] W72   = 3'h3;
    localparam logic [2:0] W144  = 3'h4;

    typedef enum logic [1:0] {MODE_TDP, MODE_SDP, MODE_SP, MODE_FIFO} lrb_mode_t;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [PADDR_W-1:0] OFS_CFG      = 12'h000;
    localparam logic [PADDR_W-1:0] OFS_STATUS   = 12'h004;
    localparam logic [PADDR_W-1:0] OFS_FIFO_CNT = 12'h008;
    localparam logic [6:0]         REG_ADDR     = 7'h00;
    localparam logic [6:0]         REG_BYTEEN   = 7'h04;
    localparam logic [6:0]         REG_CMD      = 7'h08;
    localparam logic [6:0]         REG_WDATA    = 7'h20;
    localparam logic [6:0]         REG_RDATA    = 7'h40;
    localparam logic [2:0]         DATA_WORDS   = 3'h5;

    localparam int CFG_MODE   = 0;
    localparam int CFG_WA     = 2;
    localparam int CFG_WB     = 5;
    localparam int CFG_OREG_A = 8;
    localparam int CFG_NOPAR  = 10;

    localparam logic [CFG_W-1:0] CFG_RST    = 11'h000;
    localparam logic [BE_W-1:0]  BYTEEN_RST = 8'hff;

endpackage

// [rtl/lrb_ram_core.sv]
`timescale 1ns/1ps
module lrb_ram_core (
    input  wire logic                                   clk,
    input  wire logic                                   ce,
    input  wire logic [1:0]                             en,
    input  wire logic [1:0]                             we,
    input  wire logic [1:0][lrb_pkg::ADDR_W-1:0]        base,
    input  wire logic [1:0][lrb_pkg::LANES-1:0]         lane_en,
    input  wire logic [1:0][lrb_pkg::DATA_W-1:0]        wdata,
    output logic      [1:0][lrb_pkg::DATA_W-1:0]        rdata
);
    import lrb_pkg::*;

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic [LANE_W-1:0] mem [MEM_BYTES];

    // No reset and no preload: contents stay undefined until written.
    // Reads return old data when the other port writes the same byte.
    always_ff @(posedge clk) begin // [R1] [R3]
        if (ce) begin
            for (int p = 0; p < 2; p++) begin
                for (int i = 0; i < LANES; i++) begin
                    if (en[p] && we[p] && lane_en[p][i]) begin // [R16] [R19]
                        mem[ADDR_W'(base[p] + ADDR_W'(i))] <= wdata[p][i*LANE_W +: LANE_W];
                    end
                    if (en[p] && !we[p]) begin
                        rdata[p][i*LANE_W +: LANE_W] <= lane_en[p][i] ?
                            mem[ADDR_W'(base[p] + ADDR_W'(i))] : '0;
                    end
                end
            end
        end
    end

endmodule

// [bench/lrb_apb_master.sv]
`timescale 1ns/1ps
module lrb_apb_master (
    input  wire logic                        pclk,
    output logic                             psel,
    output logic                             penable,
    output logic                             pwrite,
    output logic [lrb_pkg::PADDR_W-1:0]      paddr,
    output logic [31:0]                      pwdata,
    input  wire logic                        pready,
    input  wire logic [31:0]                 prdata,
    input  wire logic                        pslverr
);
    import lrb_pkg::*;
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end
    // ---------------------------------------------------------------
    // One transfer, held until pready is seen at a rising edge
    // ---------------------------------------------------------------
    task automatic xfer(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data must not keep looking valid
        pwdata  <= ~d;
        paddr   <= ~a;
    endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
    import lrb_pkg::*;
    logic               pclk, presetn, pclken, psel, penable, pwrite, pready, pslverr, err, np;
    logic [PADDR_W-1:0] paddr;
    logic [31:0]        pwdata, prdata, rd, v0, v1;
    logic [143:0]       img, nd, got;
    logic [15:0]        be, a;
    logic [2:0]         cw [2];
    int                 mismatches, n_checks, cycles;

    lrb_ram_block dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    lrb_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    // ---------------------------------------------------------------
    // Checking and closing
    // ---------------------------------------------------------------
    task automatic chk_reg(string name, logic [31:0] exp, logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic chk_data(string name, logic [143:0] exp, logic [143:0] seen);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Expectations
    // ---------------------------------------------------------------
    function automatic int wbits(logic [2:0] c, logic n);
        return (n ? 8 : 9) << c;
    endfunction
    function automatic logic [143:0] wmask(logic [2:0] c, logic n);
        return {144{1'b1}} >> (144 - wbits(c, n));
    endfunction
    // 9-bit writes have no lane mask, so lane 0 is always taken there
    function automatic logic [143:0] merge(logic [143:0] o, logic [143:0] n, logic [15:0] b,
                                           logic [2:0] c, logic p);
        logic [143:0] r;
        int           lw;
        lw = p ? 8 : 9;
        r = o;
        for (int i = 0; i < (1 << c); i++)
            if (c == 0 || b[i]) for (int j = 0; j < lw; j++) r[i*lw+j] = n[i*lw+j];
        return r & wmask(c, p);
    endfunction
    function automatic logic [143:0] rnd();
        logic [159:0] t;
        t = {$urandom, $urandom, $urandom, $urandom, $urandom};
        return t[143:0];
    endfunction
    function automatic logic [11:0] pa(bit p, logic [6:0] o);
        return (p ? 12'h100 : 12'h080) + {5'h00, o};
    endfunction

    // ---------------------------------------------------------------
    // Register and memory operations
    // ---------------------------------------------------------------
    task automatic wr(logic [11:0] ad, logic [31:0] d);
        m.xfer(1'b1, ad, d, rd, err);
    endtask
    task automatic rdr(logic [11:0] ad, output logic [31:0] d);
        m.xfer(1'b0, ad, 32'h0000_0000, d, err);
    endtask
    task automatic poll;
        logic [31:0] s;
        s = 32'h0000_0018;
        for (int i = 0; i < 16 && s[4:3] != 2'b00; i++) rdr(OFS_STATUS, s);
    endtask
    task automatic setcfg(logic [1:0] md, logic [2:0] wa, logic [2:0] wb, logic [1:0] o,
                          logic n);
        cw[0] = wa;
        cw[1] = wb;
        np = n;
        wr(OFS_CFG, {21'h00_0000, n, o, wb, wa, md});
    endtask
    task automatic mem(bit p, bit w, logic [15:0] ad, logic [7:0] b, logic [143:0] d,
                       output logic [143:0] q);
        logic [159:0] dd;
        logic [159:0] qq;
        int           nw;
        dd = {16'h0000, d};
        qq = '0;
        nw = (wbits(cw[p], np) + 31) / 32;
        wr(pa(p, REG_ADDR), {16'h0000, ad});
        if (w) begin
            wr(pa(p, REG_BYTEEN), {24'h00_0000, b});
            for (int k = 0; k < nw; k++) wr(pa(p, REG_WDATA) + 12'(4*k), dd[32*k +: 32]);
        end
        wr(pa(p, REG_CMD), {31'h0000_0000, w});
        poll();
        if (!w) for (int k = 0; k < nw; k++) rdr(pa(p, REG_RDATA) + 12'(4*k), qq[32*k +: 32]);
        q = qq[143:0];
    endtask
    task automatic illegal(logic [1:0] md, logic [2:0] wa, logic [2:0] wb, logic e);
        setcfg(md, wa, wb, 2'b00, 1'b0);
        wr(pa(1, REG_CMD), 32'h0000_0000);
        rdr(OFS_STATUS, rd);
        chk_reg("cfg_illegal", {27'h000_0000, !e, 3'h0, e}, {27'h000_0000, rd[4], 3'h0, rd[0]});
    endtask

    // ---------------------------------------------------------------
    // Clock, reset and hang guard
    // ---------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        presetn = 1'b0;
        pclken = 1'b1;
        void'($urandom(20));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        cw[0] = 3'h0;
        cw[1] = 3'h0;
        np = 1'b0;
        rdr(OFS_CFG, rd);
        chk_reg("cfg_reset", 32'h0000_0000, rd);
        rdr(pa(0, REG_BYTEEN), rd);
        chk_reg("byteen_reset", 32'h0000_00ff, rd);
        m.xfer(1'b0, 12'hffc, 32'h0000_0000, rd, err);
        chk_reg("unmapped_err", 32'h0000_0001, {31'h0000_0000, err});
        chk_reg("unmapped_data", 32'h0000_0000, rd);
        // Never written, so the stored byte is still unknown
        mem(1, 0, 16'h0005, 8'h00, '0, got);
        chk_data("unwritten", {135'h0, 9'bx_xxxx_xxxx}, got);
        for (int c = 0; c < 4; c++) begin
            setcfg(2'd0, 3'(c), 3'(c), 2'b00, 1'b0);
            a = c[0] ? 16'($urandom_range(0, (65536 >> c) - 1)) : 16'((65536 >> c) - 1);
            img = rnd() & wmask(3'(c), 1'b0);
            mem(0, 1, a, 8'hff, img, got);
            mem(1, 0, a, 8'h00, '0, got);
            chk_data("tdp_read", img, got);
            nd = rnd();
            be = (c == 3) ? 16'h0081 : 16'($urandom);
            mem(0, 1, a, be[7:0], nd, got);
            img = merge(img, nd, be, 3'(c), 1'b0);
            mem(0, 0, a, 8'h00, '0, got);
            chk_data("masked", img, got);
        end
        setcfg(2'd0, 3'h3, 3'h0, 2'b11, 1'b0);
        img = rnd() & wmask(3'h3, 1'b0);
        mem(0, 1, 16'h0010, 8'hff, img, got);
        mem(1, 0, 16'h0087, 8'h00, '0, got);
        chk_data("mixed_oreg", {135'h0, img[71:63]}, got);
        setcfg(2'd1, 3'h4, 3'h4, 2'b00, 1'b0);
        img = rnd();
        wr(pa(1, REG_BYTEEN), 32'h0000_00ff);
        mem(0, 1, 16'h0fff, 8'hff, img, got);
        nd = rnd();
        be = 16'($urandom) | 16'h8001;
        wr(pa(1, REG_BYTEEN), {24'h00_0000, be[15:8]});
        mem(0, 1, 16'h0fff, be[7:0], nd, got);
        mem(1, 0, 16'h0fff, 8'h00, '0, got);
        chk_data("sdp144", merge(img, nd, be, 3'h4, 1'b0), got);
        setcfg(2'd0, 3'h1, 3'h1, 2'b00, 1'b1);
        img = rnd() & wmask(3'h1, 1'b1);
        mem(0, 1, 16'h0123, 8'hff, img, got);
        nd = rnd();
        mem(0, 1, 16'h0123, 8'h02, nd, got);
        mem(1, 0, 16'h0123, 8'h00, '0, got);
        chk_data("no_parity", merge(img, nd, 16'h0002, 3'h1, 1'b1), got);
        setcfg(2'd2, 3'h2, 3'h2, 2'b01, 1'b0);
        img = rnd() & wmask(3'h2, 1'b0);
        mem(0, 1, 16'h0042, 8'hff, img, got);
        mem(0, 0, 16'h0042, 8'h00, '0, got);
        chk_data("sp_oreg", img, got);
        illegal(2'd0, 3'h4, 3'h4, 1'b1);
        illegal(2'd1, 3'h4, 3'h3, 1'b1);
        illegal(2'd1, 3'h3, 3'h4, 1'b1);
        illegal(2'd1, 3'h3, 3'h0, 1'b0);
        illegal(2'd0, 3'h3, 3'h2, 1'b0);
        setcfg(2'd3, 3'h1, 3'h1, 2'b00, 1'b0);
        v0 = $urandom & 32'h0003_ffff;
        v1 = $urandom & 32'h0003_ffff;
        wr(pa(0, REG_WDATA), v0);
        wr(pa(0, REG_CMD), 32'h0000_0001);
        // Freeze with the push pending; it must survive the stall
        pclken <= 1'b0;
        repeat (4) @(posedge pclk);
        pclken <= 1'b1;
        wr(pa(0, REG_WDATA), v1);
        wr(pa(0, REG_CMD), 32'h0000_0001);
        poll();
        rdr(OFS_FIFO_CNT, rd);
        chk_reg("fifo_count", 32'h0000_0002, rd);
        wr(pa(1, REG_CMD), 32'h0000_0000);
        poll();
        rdr(pa(1, REG_RDATA), rd);
        chk_reg("fifo_pop0", v0, rd);
        wr(pa(1, REG_CMD), 32'h0000_0000);
        poll();
        rdr(pa(1, REG_RDATA), rd);
        chk_reg("fifo_pop1", v1, rd);
        wr(pa(1, REG_CMD), 32'h0000_0000);
        rdr(OFS_STATUS, rd);
        chk_reg("fifo_empty_pop", 32'h0000_0002, rd);
        final_report();
    end
endmodule
